// ---- verilog/scc_pkg.sv ----
// constants shared by the converter control block
package scc_pkg;
  // register byte offsets
  localparam logic [7:0] CTL_OFF = 8'h00;
  localparam logic [7:0] CLK_OFF = 8'h04;
  localparam logic [7:0] DIFF_OFF = 8'h08;
  localparam logic [7:0] OVS_OFF = 8'h0C;
  localparam logic [7:0] STAT_OFF = 8'h10;
  // control register fields
  localparam int CTL_ON = 0;
  localparam int CTL_CAL = 1;
  localparam int CTL_CALMODE = 2;
  localparam int CTL_CALRST = 3;
  localparam int CTL_RES_LO = 4;
  localparam int CTL_ALIGN = 6;
  localparam int CTL_IEN_LO = 7;
  // clock register fields
  localparam int CLK_SYNC_LO = 0;
  localparam int CLK_ADIV_LO = 4;
  // oversampler register fields
  localparam int OVS_EN = 0;
  localparam int OVS_RATIO_LO = 4;
  localparam int OVS_SHIFT_LO = 16;
  // status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_VALID = 1;
  localparam int STAT_ON = 2;
  localparam int STAT_ASYNC = 3;
  // widths and limits
  localparam int DIFF_W = 22;
  localparam int NUM_CH = 21;
  localparam int RAW_W = 14;
  localparam int RATIO_W = 10;
  localparam int SHIFT_W = 4;
  localparam int ACC_W = RAW_W + RATIO_W;
  localparam int CAL_CYC_WIDE = 1082;
  localparam int CAL_CYC_NARROW = 46;
  localparam int RATIO_MAX_WIDE = 1024;
  localparam int RATIO_MAX_NARROW = 256;
  localparam int SHIFT_MAX_WIDE = 11;
  localparam int SHIFT_MAX_NARROW = 8;
  localparam logic [31:0] CTL_RST = 32'h0000_0000;
  typedef enum logic {SCC_CAL_IDLE, SCC_CAL_RUN} scc_cal_t;
endpackage

// ---- verilog/scc_ctrl.sv ----
// control, calibration, clocking and oversampling logic of the converter
// Function
// - calib start begins calibration, self-clears when done
// - calibration factor kept until power-off
// - mode bit picks offset-only or offset-plus-mismatch; third instance always offset-only
// - calib reset discards stored calibration factor
// - calibration lasts 1082 or 46 converter clocks
// - nonzero sync select divides bus clock 2..14
// - zero sync select uses divided async source
// - second instance counts calibration on first instance's clock; its converter_clock output is its own undivided async pin
// - enable low holds reset and powers off
// - differential select per channel, written while off
// - resolution 14/12/10/8 or 12/10/8/6 bits
// - result lsb or msb aligned, 32/16 bits
// - oversampling ratio 2x to 1024x or 256x
// - oversampler right shift up to 11 or 8
// - interrupt sources: end, watchdog, overflow
// - twenty-one multiplexed channels per instance
// - differential 12-bit codes pass unchanged, right aligned
`timescale 1ns/1ps
module scc_ctrl
  import scc_pkg::*;
#(
  parameter int INST = 0
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic async_clk_pin,
  input wire logic shared_tick_in,
  input wire logic [RAW_W-1:0] raw_code,
  input wire logic raw_valid,
  output logic converter_clock,
  output logic core_rst_b,
  output logic analog_power_on,
  output logic calib_run,
  output logic calib_offset_only,
  output logic calib_clear,
  output logic calib_factor_valid,
  output logic [DIFF_W-1:0] diff_channel_select,
  output logic [1:0] res_sel,
  output logic [2:0] int_enable,
  output logic [31:0] result_data,
  output logic result_valid
);
  localparam bit WIDE = (INST != 2);
  localparam int CAL_CYC = WIDE ? CAL_CYC_WIDE : CAL_CYC_NARROW;
  localparam int RATIO_MAX = WIDE ? RATIO_MAX_WIDE : RATIO_MAX_NARROW;
  localparam int SHIFT_MAX = WIDE ? SHIFT_MAX_WIDE : SHIFT_MAX_NARROW;
  localparam int RES_OUT_W = WIDE ? 32 : 16;

  // elaboration checks: instance number and channel count must fit the logic
  if (INST < 0 || INST > 2) begin
    $error("scc_ctrl: INST must be 0, 1 or 2");
  end
  if (NUM_CH > DIFF_W) begin
    $error("scc_ctrl: more channels than differential select bits");
  end

  // byte-lane merge used by every writable register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (d & m);
  endfunction

  logic converter_on;
  logic calib_mode_sel;
  logic align_msb;
  logic [2:0] sync_clk_select;
  logic [3:0] async_clk_divider;
  logic ovs_en;
  logic [RATIO_W-1:0] ovs_ratio_m1;
  logic [SHIFT_W-1:0] ovs_shift;
  scc_cal_t cal_state;
  logic [10:0] cal_cnt;
  logic [3:0] div_cnt;
  logic [3:0] async_cnt;
  logic [2:0] pin_sync;
  logic pin_level;
  logic [RATIO_W-1:0] ovs_cnt;
  logic [ACC_W-1:0] ovs_acc;

  // bus decode
  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr_req = bus_req && wb_we_i;
  wire wr_ctl = wr_req && (wb_adr_i == CTL_OFF);
  wire wr_clk = wr_req && (wb_adr_i == CLK_OFF) && (INST != 1);
  wire wr_diff = wr_req && (wb_adr_i == DIFF_OFF) && !converter_on;
  wire wr_ovs = wr_req && (wb_adr_i == OVS_OFF);
  wire [31:0] ctl_word = {22'h0, int_enable, align_msb, res_sel, 1'b0, calib_mode_sel,
                          (cal_state == SCC_CAL_RUN), converter_on};
  wire [31:0] clk_word = {24'h0, async_clk_divider, 1'b0, sync_clk_select};
  wire [31:0] ovs_word = {12'h0, ovs_shift, 2'b0, ovs_ratio_m1, 3'b0, ovs_en};
  wire [31:0] stat_word = {28'h0, (sync_clk_select == 3'h0), converter_on,
                           calib_factor_valid, (cal_state == SCC_CAL_RUN)};
  wire [31:0] ctl_new = merge(ctl_word, wb_dat_i, wb_sel_i);
  wire [31:0] clk_new = merge(clk_word, wb_dat_i, wb_sel_i);
  wire [31:0] diff_new = merge({10'h0, diff_channel_select}, wb_dat_i, wb_sel_i);
  wire [31:0] ovs_new = merge(ovs_word, wb_dat_i, wb_sel_i);
  wire [RATIO_W-1:0] ratio_req = ovs_new[OVS_RATIO_LO +: RATIO_W];
  wire [SHIFT_W-1:0] shift_req = ovs_new[OVS_SHIFT_LO +: SHIFT_W];
  wire [31:0] rd_word = (wb_adr_i == CTL_OFF) ? ctl_word :
                        (wb_adr_i == CLK_OFF) ? clk_word :
                        (wb_adr_i == DIFF_OFF) ? {10'h0, diff_channel_select} :
                        (wb_adr_i == OVS_OFF) ? ovs_word :
                        (wb_adr_i == STAT_OFF) ? stat_word : 32'h0000_0000;

  // wishbone answer: ack one cycle after the request, data registered with it
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= (bus_req && !wb_we_i) ? rd_word : 32'h0000_0000;
    end
  end

  // software-written configuration
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      converter_on <= CTL_RST[CTL_ON];
      calib_mode_sel <= 1'b0;
      res_sel <= 2'h0;
      align_msb <= 1'b0;
      int_enable <= 3'h0;
      sync_clk_select <= 3'h0;
      async_clk_divider <= 4'h0;
      diff_channel_select <= '0;
      ovs_en <= 1'b0;
      ovs_ratio_m1 <= RATIO_W'(1);
      ovs_shift <= 4'h0;
    end else begin
      if (wr_ctl) begin
        converter_on <= ctl_new[CTL_ON];
        calib_mode_sel <= WIDE && ctl_new[CTL_CALMODE];
        res_sel <= ctl_new[CTL_RES_LO +: 2];
        align_msb <= ctl_new[CTL_ALIGN];
        int_enable <= ctl_new[CTL_IEN_LO +: 3];
      end
      if (wr_clk) begin
        sync_clk_select <= clk_new[CLK_SYNC_LO +: 3];
        async_clk_divider <= clk_new[CLK_ADIV_LO +: 4];
      end
      if (wr_diff) begin
        diff_channel_select <= diff_new[DIFF_W-1:0];
      end
      if (wr_ovs) begin
        ovs_en <= ovs_new[OVS_EN];
        // ratios clamp to 2x .. max, shifts to the instance maximum
        ovs_ratio_m1 <= (ratio_req == '0) ? RATIO_W'(1) :
                        (32'(ratio_req) > RATIO_MAX - 1) ? RATIO_W'(RATIO_MAX - 1) :
                        ratio_req;
        ovs_shift <= (32'(shift_req) > SHIFT_MAX) ? SHIFT_W'(SHIFT_MAX) : shift_req;
      end
    end
  end

  // enable gating of the converter core
  assign core_rst_b = converter_on;
  assign analog_power_on = converter_on;

  // converter clock: bus clock divided by 2*select, or divided async pin
  wire sync_mode = (sync_clk_select != 3'h0);
  wire [3:0] sync_last = {sync_clk_select, 1'b0} - 4'h1;
  wire async_rise = pin_sync[2] && pin_sync[1] && !pin_level; // filtered level rises
  wire own_tick = sync_mode ? (div_cnt == sync_last) :
                  (async_rise && (async_cnt == async_clk_divider));
  wire conv_tick = (INST == 1) ? shared_tick_in : own_tick;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pin_sync <= 3'h0;
      pin_level <= 1'b0;
      div_cnt <= 4'h0;
      async_cnt <= 4'h0;
      converter_clock <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[1:0], async_clk_pin};
      // a pin change counts only once the second and third stages agree
      pin_level <= (pin_sync[1] == pin_sync[2]) ? pin_sync[2] : pin_level;
      div_cnt <= (!converter_on || own_tick) ? 4'h0 : div_cnt + 4'h1;
      if (!converter_on || (async_rise && async_cnt == async_clk_divider)) begin
        async_cnt <= 4'h0;
      end else if (async_rise) begin
        async_cnt <= async_cnt + 4'h1;
      end
      converter_clock <= converter_on && own_tick;
    end
  end

  // foreground calibration sequencer counted in converter clocks
  wire cal_start = wr_ctl && ctl_new[CTL_CAL] && ctl_new[CTL_ON] && converter_on;
  // enable as it stands after this edge, so a switch-off acts at its own write edge
  wire on_next = wr_ctl ? ctl_new[CTL_ON] : converter_on;
  wire cal_wipe = wr_ctl && ctl_new[CTL_CALRST];
  wire cal_last = conv_tick && (cal_cnt == 11'(CAL_CYC - 1));
  assign calib_run = (cal_state == SCC_CAL_RUN);
  assign calib_offset_only = !calib_mode_sel;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cal_state <= SCC_CAL_IDLE;
      cal_cnt <= 11'h000;
      calib_factor_valid <= 1'b0;
      calib_clear <= 1'b0;
    end else begin
      calib_clear <= cal_wipe;
      unique case (cal_state)
        SCC_CAL_IDLE: begin
          cal_cnt <= 11'h000;
          if (cal_start) cal_state <= SCC_CAL_RUN;
        end
        SCC_CAL_RUN: begin
          if (!on_next) begin
            cal_state <= SCC_CAL_IDLE;
          end else if (cal_last) begin
            cal_state <= SCC_CAL_IDLE;
          end else if (conv_tick) begin
            cal_cnt <= cal_cnt + 11'h001;
          end
        end
      endcase
      // factor survives until power-off or an explicit reset
      if (!on_next || cal_wipe) begin
        calib_factor_valid <= 1'b0;
      end else if (cal_state == SCC_CAL_RUN && cal_last) begin
        calib_factor_valid <= 1'b1;
      end
    end
  end

  // result path: oversampler output shifted right by ovs_shift, or raw code lsb or msb aligned
  wire [4:0] res_bits = WIDE ? (5'h0E - {2'b0, res_sel, 1'b0}) :
                        (5'h0C - {2'b0, res_sel, 1'b0});
  wire [ACC_W-1:0] acc_sum = ovs_acc + ACC_W'(raw_code);
  wire ovs_done = raw_valid && (ovs_cnt == ovs_ratio_m1);
  wire [ACC_W-1:0] ovs_out = acc_sum >> ovs_shift;
  wire [4:0] msb_pad = 5'h10 - res_bits;
  wire [31:0] lsb_val = ovs_en ? 32'(ovs_out) : 32'(raw_code);
  wire [31:0] msb_val = ovs_en ? 32'(ovs_out) : (32'(raw_code) << msb_pad);
  wire [31:0] aligned = align_msb ? msb_val : lsb_val;
  wire [31:0] out_mask = (RES_OUT_W == 32) ? 32'hFFFF_FFFF : 32'h0000_FFFF;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ovs_cnt <= '0;
      ovs_acc <= '0;
      result_data <= 32'h0000_0000;
      result_valid <= 1'b0;
    end else begin
      result_valid <= 1'b0;
      if (!converter_on || !ovs_en) begin
        ovs_cnt <= '0;
        ovs_acc <= '0;
        if (converter_on && raw_valid) begin
          result_data <= aligned & out_mask;
          result_valid <= 1'b1;
        end
      end else if (ovs_done) begin
        ovs_cnt <= '0;
        ovs_acc <= '0;
        result_data <= aligned & out_mask;
        result_valid <= 1'b1;
      end else if (raw_valid) begin
        ovs_cnt <= ovs_cnt + RATIO_W'(1);
        ovs_acc <= acc_sum;
      end
    end
  end

  // helper: cycles since the last own converter clock tick
  logic [4:0] gap;
  logic gap_ok;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gap <= 5'h00;
      gap_ok <= 1'b0;
    end else begin
      gap <= own_tick ? 5'h01 : gap + 5'h01;
      gap_ok <= (own_tick || gap_ok) && sync_mode && !wr_clk && converter_on;
    end
  end

  AST_CAL_ENDS: assert property (@(posedge clock) disable iff (!rst_b)
    calib_run && cal_last && on_next && !cal_wipe |=> !calib_run && calib_factor_valid)
    else $error("calibration did not end after its count");
  AST_CAL_HOLDS: assert property (@(posedge clock) disable iff (!rst_b)
    calib_run && !cal_last && on_next |=> calib_run)
    else $error("calibration ended early");
  AST_FACTOR_OFF: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(converter_on) |-> !calib_factor_valid && !calib_run)
    else $error("calibration state survived power-off");
  AST_CAL_RESET: assert property (@(posedge clock) disable iff (!rst_b)
    calib_clear |-> !calib_factor_valid)
    else $error("calibration reset left factor valid");
  AST_DIFF_LOCK: assert property (@(posedge clock) disable iff (!rst_b)
    converter_on |=> $stable(diff_channel_select))
    else $error("differential select changed while enabled");
  AST_SYNC_DIV: assert property (@(posedge clock) disable iff (!rst_b)
    own_tick && gap_ok && $stable(sync_clk_select) |-> gap == {1'b0, sync_clk_select, 1'b0})
    else $error("sync converter clock period wrong");
  AST_RUN_NEEDS_ON: assert property (@(posedge clock) disable iff (!rst_b)
    calib_run |-> ##1 (calib_run |-> $past(converter_on)))
    else $error("calibration ran while disabled");
  AST_OVS_LIMITS: assert property (@(posedge clock) disable iff (!rst_b)
    ovs_ratio_m1 != '0 && 32'(ovs_ratio_m1) <= RATIO_MAX - 1)
    else $error("oversampling ratio outside range");
  AST_SHIFT_LIMIT: assert property (@(posedge clock) disable iff (!rst_b)
    32'(ovs_shift) <= SHIFT_MAX)
    else $error("oversampler shift above maximum");
  AST_WB_ACK: assert property (@(posedge clock) disable iff (!rst_b)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack timing wrong");
endmodule

// ---- testbench/scc_core_model.sv ----
// behavioural converter core and asynchronous clock source facing the control block
`timescale 1ns/1ps
module scc_core_model
  import scc_pkg::*;
#(
  parameter int STARTUP = 20
) (
  input wire logic clock,
  input wire logic core_rst_b,
  input wire logic analog_power_on,
  input wire logic conv_req,
  input wire logic [RAW_W-1:0] conv_code,
  output logic [RAW_W-1:0] raw_code,
  output logic raw_valid,
  output logic async_clk_pin
);
  int up_cnt = 0;
  // free-running source, phase unrelated to the bus clock
  initial begin
    raw_code = '0;
    raw_valid = 1'b0;
    async_clk_pin = 1'b0;
    #3;
    forever #40 async_clk_pin = ~async_clk_pin;
  end
  // converts only once power-up has settled; code lines keep changing outside results
  always @(posedge clock) begin
    up_cnt <= (core_rst_b && analog_power_on) ? up_cnt + 1 : 0;
    raw_valid <= conv_req && (up_cnt >= STARTUP);
    raw_code <= (conv_req && (up_cnt >= STARTUP)) ? conv_code : ~raw_code;
  end
endmodule

// ---- testbench/tb.sv ----
// self-checking bench for the converter control block
`timescale 1ns/1ps
module tb
  import scc_pkg::*;
;
  logic clock = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, req = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, res, v, sum;
  logic [RAW_W-1:0] code = 14'h0, raw, c;
  logic ack, rv, tick, apin, crst_b, pwr, run, ofs, clr, fv, resv;
  logic [DIFF_W-1:0] dsel;
  logic [1:0] rsel;
  logic [2:0] ien;
  logic [31:0] rd_q[$], res_q[$];
  int err_total = 0, n_checks = 0, clr_cnt = 0, n;
  int seed = 32'hBA489B1E;
  scc_ctrl #(.INST(0)) scc_ctrl_i (.clock(clock), .rst_b(rst_b), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .async_clk_pin(apin), .shared_tick_in(1'b0),
    .raw_code(raw), .raw_valid(rv), .converter_clock(tick), .core_rst_b(crst_b),
    .analog_power_on(pwr), .calib_run(run), .calib_offset_only(ofs), .calib_clear(clr),
    .calib_factor_valid(fv), .diff_channel_select(dsel), .res_sel(rsel),
    .int_enable(ien), .result_data(res), .result_valid(resv));
  scc_core_model scc_core_model_i (.clock(clock), .core_rst_b(crst_b),
    .analog_power_on(pwr), .conv_req(req), .conv_code(code), .raw_code(raw),
    .raw_valid(rv), .async_clk_pin(apin));
  // bus clock
  initial begin
    forever #5 clock = ~clock;
  end
  task automatic summarize;
    if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic bail;
    err_total++;
    summarize();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic cycle: hold until ack is sampled high, then release
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    @(posedge clock);
    while (ack !== 1'b1 && k < 50) begin
      k++;
      @(posedge clock);
    end
    if (k >= 50) bail();
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic tw;
    int k;
    k = 0;
    @(negedge clock);
    while (tick !== 1'b1 && k < 400) begin
      k++;
      @(negedge clock);
    end
    if (k >= 400) bail();
  endtask
  task automatic gap(input int e);
    tw();
    tw();
    n = 1;
    @(negedge clock);
    while (tick !== 1'b1 && n < 400) begin
      n++;
      @(negedge clock);
    end
    chk("tick gap", e, n);
  endtask
  task automatic samp(input logic [RAW_W-1:0] s);
    @(posedge clock);
    req <= 1'b1;
    code <= s;
    @(posedge clock);
    req <= 1'b0;
  endtask
  // pairs each read answer and each result with the oldest note
  always @(negedge clock) begin
    if (ack === 1'b1 && we === 1'b0) chk("read data", rd_q.pop_front(), rdat);
    if (resv === 1'b1) chk("result", res_q.pop_front(), res);
    if (clr === 1'b1) clr_cnt++;
  end
  // hang guard
  initial begin
    #900000;
    bail();
  end
  // main sequence
  initial begin
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    rd(CTL_OFF, 32'h0);
    rd(CLK_OFF, 32'h0);
    rd(OVS_OFF, 32'h10);
    rd(STAT_OFF, 32'h8);
    rd(8'h20, 32'h0);
    chk("core reset", 0, crst_b);
    chk("power", 0, pwr);
    v = $random(seed) & 32'h003F_FFFF;
    wr(DIFF_OFF, v);
    rd(DIFF_OFF, v);
    chk("diff select", v, dsel);
    // the converter clock only runs while the converter is on
    wr(CTL_OFF, 32'h1);
    chk("core reset", 1, crst_b);
    for (int s = 1; s < 8; s++) begin
      wr(CLK_OFF, s);
      gap(2 * s);
    end
    wr(CLK_OFF, 32'h20);
    gap(24);
    rd(STAT_OFF, 32'hC);
    wr(CLK_OFF, 32'h1);
    wr(DIFF_OFF, ~v);
    rd(DIFF_OFF, v);
    for (int i = 0; i < 3; i++) begin
      wr(CTL_OFF, 1 | (1 << (CTL_IEN_LO + i)));
      chk("irq enables", 1 << i, ien);
    end
    for (int p = 0; p < 2; p++) begin
      wr(CTL_OFF, 32'h1);
      repeat (14) tw();
      wr(CTL_OFF, 32'h9);
      chk("clear pulses", 2 * p + 1, clr_cnt);
      wr(CTL_OFF, 32'h3 | (p << CTL_CALMODE));
      chk("offset only", !p, ofs);
      rd(CTL_OFF, 32'h3 | (p << CTL_CALMODE));
      n = 0;
      while (run === 1'b1 && n < 3000) begin
        n++;
        @(negedge clock);
      end
      if (n >= 3000) bail();
      chk("calib length", 1, n >= 2160 && n <= 2161);
      chk("factor valid", 1, fv);
      rd(STAT_OFF, 32'h6);
      rd(CTL_OFF, 32'h1 | (p << CTL_CALMODE));
      wr(CTL_OFF, p ? 32'h0 : 32'h9);
      chk("factor dropped", 0, fv);
    end
    wr(CTL_OFF, 32'h1);
    repeat (14) tw();
    for (int r = 0; r < 4; r++) begin
      for (int a = 0; a < 2; a++) begin
        wr(CTL_OFF, 1 | (r << CTL_RES_LO) | (a << CTL_ALIGN));
        chk("resolution", r, rsel);
        c = $random(seed) & ((1 << (14 - 2 * r)) - 1);
        v = {18'h0, c};
        res_q.push_back(a ? v << (2 + 2 * r) : v);
        samp(c);
      end
    end
    wr(CTL_OFF, 32'h11);
    for (int i = 0; i < 3; i++) begin
      c = (i == 0) ? 14'hFFF : (i == 1) ? 14'h000 : 14'h7FF;
      res_q.push_back({18'h0, c});
      samp(c);
    end
    wr(CTL_OFF, 32'h1);
    for (int t = 0; t < 2; t++) begin
      int ratio, sh;
      ratio = t ? 1024 : 4;
      sh = t ? 11 : 2;
      wr(OVS_OFF, 1 | ((ratio - 1) << OVS_RATIO_LO) | (sh << OVS_SHIFT_LO));
      sum = 0;
      for (int i = 0; i < ratio; i++) begin
        c = $random(seed);
        sum = sum + c;
        if (i == ratio - 1) res_q.push_back(sum >> sh);
        samp(c);
      end
    end
    wr(OVS_OFF, 32'h000F_0000);
    rd(OVS_OFF, 32'h000B_0010);
    repeat (4) @(posedge clock);
    chk("pending notes", 0, rd_q.size() + res_q.size());
    summarize();
  end
endmodule
